// ==== fre_ctrl.sv ====
// Flash-ROM program/erase sequencer with register port and config decode
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fre_defs.svh"
// What this block does
// - Data region E000h-F3FFh: byte read, word program, 1K block erase, nonvolatile.
// - Command A6h erases addressed block to all ones, core stalled until done.
// - Erase selects block by upper six address bits only.
// - Command 9Ah programs data word, clearing bits only, core stalled.
// - Word program uses upper fifteen address bits, bit zero ignored.
// - Status bit 1 flags an unrecognised last command value.
// - Status bit 0 flags timeout of last erase or program.
// - Status bit 6 shows address valid; bit 7 one; bits 5-2 zero.
// - Command write and status read share address 86h.
// - Data word register at 8Eh low and 8Fh high, read/write.
// - Address register at 84h low and 85h high, read/write.
// - Flash readable by plain code-space reads, no command needed.
// - Config bit 15 zero forbids external reading, one permits it.
// - Config bit 14 picks start address 0000h or F400h.
// - Config bit 13 adds 87 ms to power-up reset.
// - Config bit 11 enables reset pin, bit 10 port 0 reset pull-ups.
// - Protected flash erasable not readable; protection lifts at next power-on.
// - Reset pin high enters programming; select is active low.
// - Eight-byte unique ID at 20h, readable with interrupts disabled and interrupt_block_flag set.
// - Erase or program refused unless region write enable is set.
// - Unlock opens 16-cycle window; protected registers writable only then.
module fre_ctrl #(
  parameter int          ERASE_CYCLES      = 600,
  parameter int          WRITE_CYCLES      = 16,
  parameter int          TOUT_CYCLES       = 2048,
  parameter int          LONG_RESET_CYCLES = `FRE_LONG_RESET_MS * `FRE_CLK_MHZ * 1000,
  parameter logic [15:0] ID_W0             = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_W1             = 16'h5678, // Arbitrary value
  parameter logic [15:0] ID_W2             = 16'h9abc  // Arbitrary value
) (
  input  wire logic        sys_clk,                   // System clock
  input  wire logic        rstn,                      // Async reset, active low
  input  wire logic [7:0]  sfr_addr,                  // Register address
  input  wire logic [7:0]  sfr_wdata,                 // Register write data
  input  wire logic        sfr_wr,                    // Write strobe
  input  wire logic        sfr_rd,                    // Read strobe
  output logic      [7:0]  sfr_rdata,                 // Read data, next cycle
  input  wire logic        code_rd,                   // Code-space read strobe
  input  wire logic [15:0] code_addr,                 // Code-space byte address
  output logic      [7:0]  code_rdata,                // Code read data, next cycle
  output logic             cpu_stall,                 // Core held while high
  input  wire logic        interrupt_block_flag,      // ID area access enable
  input  wire logic        global_int_disabled,       // Interrupts globally off
  input  wire logic        rst_pin_level,             // Reset pin level
  input  wire logic        programmer_select_n,       // Programmer select, low active
  output logic             programming_state,         // Programming state entered
  output logic             programmer_read_enable,    // Programmer may read flash
  output logic             extended_reset_hold,       // Long power-up reset running
  output logic      [15:0] boot_start_addr,           // Execution start address
  output logic             external_reset_pin_enable, // Reset pin function on
  output logic             port0_reset_pullup_enable, // Port 0 pull-ups in reset
  output logic             crystal_drive_boost,       // Stronger crystal drive
  output logic             safe_mode_active           // Unlock window open
);
  import fre_pkg::*;

  // ID checksum, wraps at 16 bits
  localparam logic [15:0] ID_SUM = 16'(ID_W0 + ID_W1 + ID_W2);
  localparam logic [63:0] ID_BYTES = {ID_SUM, ID_W2, ID_W1, ID_W0};
  localparam logic [24:0] HOLD_LAST = 25'(LONG_RESET_CYCLES - 1);
  localparam logic [15:0] TOUT_LAST = 16'(TOUT_CYCLES - 1);

  // Refuse counts the counters cannot hold
  if (TOUT_CYCLES < 1 || TOUT_CYCLES > 65536 ||
      ERASE_CYCLES < `FRE_BLOCK_WORDS || WRITE_CYCLES < 1 ||
      LONG_RESET_CYCLES < 1 || LONG_RESET_CYCLES > 33554432)
  begin : g_chk
    $error("fre_ctrl: cycle counts out of range");
  end

  // Array with its own erase and program timing
  fre_flash_if fl ();

  fre_flash_array #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_array (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .fl      (fl)
  );

  // Sequencer registers
  fre_state_type state_q;
  fre_state_type state_d;
  logic [15:0]   addr_q;
  logic [15:0]   word_q;
  logic [15:0]   cfg_q;
  logic          cmd_err_q;
  logic          tout_q;
  logic          wren_code_q;
  logic          wren_data_q;
  logic          key_armed_q;
  logic [4:0]    safe_cnt_q;
  logic [15:0]   tout_cnt_q;
  logic [24:0]   hold_cnt_q;

  // Decode and status wires
  logic          wr_cmd;
  logic          cmd_erase;
  logic          cmd_known;
  logic          in_data;
  logic          in_code;
  logic          addr_ok;
  logic          id_hit;
  logic [7:0]    status;

  // Register strobes and command decode
  // Command writes count only when idle; a held core cannot issue them
  assign wr_cmd    = sfr_wr && (sfr_addr == `FRE_OFS_CMD) && (state_q == FRE_IDLE);
  assign cmd_erase = (sfr_wdata == `FRE_CMD_ERASE);
  assign cmd_known = cmd_erase || (sfr_wdata == `FRE_CMD_WRITE);

  // Target region check against write enables
  // Code region: application space plus boot area
  assign in_data = (addr_q >= `FRE_DATA_LO) && (addr_q <= `FRE_DATA_HI);
  assign in_code = (addr_q <= `FRE_APP_HI) || (addr_q >= `FRE_BOOT_LO);
  assign addr_ok = (in_data && wren_data_q) || (in_code && wren_code_q);

  // Status layout: top bit one, middle bits zero
  assign status = {1'b1, addr_ok, 4'h0, cmd_err_q, tout_q};

  // Launch toward the array
  // Disabled target: refused silently, no stall
  assign fl.start = wr_cmd && cmd_known && addr_ok && (state_q == FRE_IDLE);
  assign fl.op    = cmd_erase ? FRE_OP_ERASE : FRE_OP_WRITE;
  assign fl.word_idx = cmd_erase ? {addr_q[15:10], 9'h000}
                                 : addr_q[15:1];
  assign fl.wdata = word_q;
  // Watchdog abort; a done in the same cycle wins
  assign fl.abort = (state_q == FRE_BUSY) && (tout_cnt_q == TOUT_LAST) && !fl.done;
  // Config word index while loading
  assign fl.rd_idx = (state_q == FRE_CFG) ? 15'(`FRE_CFG_ADDR >> 1) : code_addr[15:1];

  // Core stall while loading config, holding reset or busy
  assign cpu_stall = (state_q != FRE_IDLE);
  assign extended_reset_hold = (state_q == FRE_HOLD);

  // Decoded configuration word
  // Bits 9 to 0 are fixed by the tool, not decoded
  assign boot_start_addr = cfg_q[`FRE_CFG_BOOT] ? `FRE_BOOT_LO
                                                : `FRE_RESET_ADDR;
  assign external_reset_pin_enable = cfg_q[`FRE_CFG_RSTPIN];
  assign port0_reset_pullup_enable = cfg_q[`FRE_CFG_PULLUP];
  assign crystal_drive_boost       = cfg_q[`FRE_CFG_XTAL];

  // Programmer entry and read permission
  // Protection copy is taken at reset only
  assign programming_state = rst_pin_level;
  assign programmer_read_enable = rst_pin_level && !programmer_select_n
                                  && cfg_q[`FRE_CFG_PROTECT];

  // Window open while the countdown runs
  assign safe_mode_active = (safe_cnt_q != 5'd0);

  // ID area hit, gated by interrupt state
  // Outside the eight bytes the array answers
  assign id_hit = (code_addr >= `FRE_ID_LO) && (code_addr <= `FRE_ID_HI)
                  && interrupt_block_flag && global_int_disabled;

  // Next sequencer state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FRE_CFG:
        state_d = FRE_HOLD;
      FRE_HOLD:
        if (!cfg_q[`FRE_CFG_LONG] || hold_cnt_q == HOLD_LAST)
          state_d = FRE_IDLE;
      FRE_IDLE:
        if (fl.start)
          state_d = FRE_BUSY;
      FRE_BUSY:
        if (fl.done || fl.abort)
          state_d = FRE_IDLE;
      default:
        state_d = FRE_CFG;
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= FRE_CFG;
    else
      state_q <= state_d;
  end

  // Config capture once per reset, so protection changes at power-on
  // Read straight from the array while the core is held
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cfg_q <= `FRE_CFG_RST;
    else if (state_q == FRE_CFG)
      cfg_q <= fl.rd_word;
  end

  // Long reset counter
  // Counts only in hold, so each reset starts at zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hold_cnt_q <= 25'd0;
    else if (state_q == FRE_HOLD)
      hold_cnt_q <= hold_cnt_q + 25'd1;
    else
      hold_cnt_q <= 25'd0;
  end

  // Operation watchdog
  // Cleared outside busy: each operation gets the full span
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tout_cnt_q <= 16'h0000;
    else if (state_q == FRE_BUSY)
      tout_cnt_q <= tout_cnt_q + 16'h0001;
    else
      tout_cnt_q <= 16'h0000;
  end

  // Command error flag follows each command write
  // Known values clear it even when refused
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cmd_err_q <= 1'b0;
    else if (wr_cmd)
      cmd_err_q <= !cmd_known;
  end

  // Timeout flag; the set wins over the clear
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tout_q <= 1'b0;
    else if (fl.abort)
      tout_q <= 1'b1;
    else if (wr_cmd)
      tout_q <= 1'b0;
  end

  // Two-key unlock and window countdown
  // Any other key write closes the window early
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      key_armed_q <= 1'b0;
      safe_cnt_q  <= 5'd0;
    end
    else if (sfr_wr && sfr_addr == `FRE_OFS_KEY)
    begin
      key_armed_q <= !key_armed_q && (sfr_wdata == `FRE_KEY_FIRST);
      if (key_armed_q && sfr_wdata == `FRE_KEY_SECOND)
        safe_cnt_q <= `FRE_SAFE_CYCLES;
      else
        safe_cnt_q <= 5'd0;
    end
    else if (safe_cnt_q != 5'd0)
      safe_cnt_q <= safe_cnt_q - 5'd1;
  end

  // Region write enables, writable only inside the window
  // They outlive the window; software clears them
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wren_code_q <= 1'b0;
      wren_data_q <= 1'b0;
    end
    else if (sfr_wr && sfr_addr == `FRE_OFS_WREN && safe_mode_active)
    begin
      wren_code_q <= sfr_wdata[`FRE_WREN_CODE];
      wren_data_q <= sfr_wdata[`FRE_WREN_DATA];
    end
  end

  // Address and data word registers, no reset value
  // Byte halves load independently, in any order
  always_ff @(posedge sys_clk)
  begin
    if (sfr_wr && sfr_addr == `FRE_OFS_ADDR_LO)
      addr_q[7:0] <= sfr_wdata;
    if (sfr_wr && sfr_addr == `FRE_OFS_ADDR_HI)
      addr_q[15:8] <= sfr_wdata;
    if (sfr_wr && sfr_addr == `FRE_OFS_WORD_LO)
      word_q[7:0] <= sfr_wdata;
    if (sfr_wr && sfr_addr == `FRE_OFS_WORD_HI)
      word_q[15:8] <= sfr_wdata;
  end

  // Register read port, data valid for one cycle
  // Unmapped addresses and the key port read zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `FRE_OFS_ADDR_LO: sfr_rdata <= addr_q[7:0];
        `FRE_OFS_ADDR_HI: sfr_rdata <= addr_q[15:8];
        `FRE_OFS_CMD:     sfr_rdata <= status;
        `FRE_OFS_WORD_LO: sfr_rdata <= word_q[7:0];
        `FRE_OFS_WORD_HI: sfr_rdata <= word_q[15:8];
        `FRE_OFS_WREN:
          sfr_rdata <= {4'h0, wren_code_q, wren_data_q, 2'b00};
        default:          sfr_rdata <= 8'h00;
      endcase
    end
    else
      sfr_rdata <= 8'h00;
  end

  // Code-space reads, little-endian byte pick, ID overlay
  // Odd address takes the high byte
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      code_rdata <= 8'h00;
    else if (code_rd)
    begin
      if (id_hit)
        code_rdata <= ID_BYTES[{code_addr[2:0], 3'b000} +: 8];
      else if (code_addr[0])
        code_rdata <= fl.rd_word[15:8];
      else
        code_rdata <= fl.rd_word[7:0];
    end
  end
endmodule // fre_ctrl
`default_nettype wire

// ==== fre_defs.svh ====
// Offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef FRE_DEFS_SVH
`define FRE_DEFS_SVH
`define FRE_OFS_ADDR_LO 8'h84
`define FRE_OFS_ADDR_HI 8'h85
`define FRE_OFS_CMD 8'h86
`define FRE_OFS_WORD_LO 8'h8e
`define FRE_OFS_WORD_HI 8'h8f
`define FRE_OFS_KEY 8'h90
`define FRE_OFS_WREN 8'h91
`define FRE_CMD_ERASE 8'ha6
`define FRE_CMD_WRITE 8'h9a
`define FRE_KEY_FIRST 8'h55
`define FRE_KEY_SECOND 8'haa
`define FRE_STATUS_RST 8'h80
`define FRE_ST_TOUT 0
`define FRE_ST_CMDERR 1
`define FRE_ST_ADDROK 6
`define FRE_WREN_CODE 3
`define FRE_WREN_DATA 2
`define FRE_DATA_LO 16'he000
`define FRE_DATA_HI 16'hf3ff
`define FRE_APP_HI 16'h7fff
`define FRE_BOOT_LO 16'hf400
`define FRE_RESET_ADDR 16'h0000
`define FRE_CFG_ADDR 16'hfffe
`define FRE_ID_LO 16'h0020
`define FRE_ID_HI 16'h0027
`define FRE_CFG_PROTECT 15
`define FRE_CFG_BOOT 14
`define FRE_CFG_LONG 13
`define FRE_CFG_XTAL 12
`define FRE_CFG_RSTPIN 11
`define FRE_CFG_PULLUP 10
`define FRE_CFG_RST 16'hffff
`define FRE_SAFE_CYCLES 5'd16
`define FRE_LONG_RESET_MS 87
`define FRE_CLK_MHZ 250
`define FRE_BLOCK_WORDS 512
`endif

// ==== fre_pkg.sv ====
// Types shared by the flash sequencer modules
package fre_pkg;
  typedef enum logic [1:0] {
    FRE_CFG  = 2'b00,
    FRE_HOLD = 2'b01,
    FRE_IDLE = 2'b11,
    FRE_BUSY = 2'b10
  } fre_state_type;
  typedef enum logic [1:0] {
    FRE_OP_NONE  = 2'b00,
    FRE_OP_ERASE = 2'b01,
    FRE_OP_WRITE = 2'b10
  } fre_op_type;
endpackage

// ==== fre_flash_if.sv ====
// Command and read path between sequencer and flash array
`timescale 1ns/1ps
`default_nettype none
interface fre_flash_if;
  logic                   start;
  fre_pkg::fre_op_type    op;
  logic [14:0]            word_idx;
  logic [15:0]            wdata;
  logic                   abort;
  logic                   done;
  logic [14:0]            rd_idx;
  logic [15:0]            rd_word;
  modport ctrl (output start, op, word_idx, wdata, abort, rd_idx, input done, rd_word);
  modport array (input start, op, word_idx, wdata, abort, rd_idx, output done, rd_word);
endinterface
`default_nettype wire

// ==== fre_flash_array.sv ====
// Flash array storage with timed block erase and word program
`timescale 1ns/1ps
`default_nettype none
module fre_flash_array #(
  parameter int ERASE_CYCLES = 600,
  parameter int WRITE_CYCLES = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn,    // Async reset, active low
  fre_flash_if.array fl     // Sequencer side
);
  import fre_pkg::*;

  logic [15:0] mem_q [0:32767];
  logic        busy_q;
  fre_op_type  op_q;
  logic [15:0] cnt_q;
  logic [14:0] idx_q;
  logic [15:0] data_q;
  logic [15:0] last;

  if (ERASE_CYCLES < `FRE_BLOCK_WORDS || ERASE_CYCLES > 65535 ||
      WRITE_CYCLES < 1 || WRITE_CYCLES > 65535)
  begin : g_chk
    $error("fre_flash_array: cycle counts out of range");
  end

  // Last cycle of the running operation
  assign last = (op_q == FRE_OP_ERASE) ? 16'(ERASE_CYCLES - 1) : 16'(WRITE_CYCLES - 1);
  assign fl.done = busy_q && (cnt_q == last);
  assign fl.rd_word = mem_q[fl.rd_idx];

  // Operation sequencing
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q <= 1'b0;
      op_q   <= FRE_OP_NONE;
      cnt_q  <= 16'h0000;
      idx_q  <= 15'h0000;
      data_q <= 16'h0000;
    end
    else if (fl.start && !busy_q)
    begin
      busy_q <= 1'b1;
      op_q   <= fl.op;
      cnt_q  <= 16'h0000;
      idx_q  <= fl.word_idx;
      data_q <= fl.wdata;
    end
    else if (fl.abort || fl.done)
      busy_q <= 1'b0;
    else if (busy_q)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Cell updates: erase walks the block, program only clears bits;
  // a plain process, so a simulation preload may also write the cells
  always @(posedge sys_clk)
  begin
    if (busy_q && !fl.abort && op_q == FRE_OP_ERASE && cnt_q < 16'(`FRE_BLOCK_WORDS))
      mem_q[{idx_q[14:9], cnt_q[8:0]}] <= 16'hffff;
    else if (fl.done && op_q == FRE_OP_WRITE)
      mem_q[idx_q] <= mem_q[idx_q] & data_q;
  end
endmodule // fre_flash_array
`default_nettype wire

// ==== fre_checker.sv ====
// Port-level assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fre_checker #(
  parameter int TOUT_CYCLES       = 2048,
  parameter int LONG_RESET_CYCLES = 21750000
) (
  input wire logic        sys_clk,                // Clock
  input wire logic        rstn,                   // Reset, low
  input wire logic [7:0]  sfr_addr,               // Address
  input wire logic [7:0]  sfr_wdata,              // Write data
  input wire logic        sfr_wr,                 // Write strobe
  input wire logic        sfr_rd,                 // Read strobe
  input wire logic [7:0]  sfr_rdata,              // Read data
  input wire logic        code_rd,                // Code strobe
  input wire logic [7:0]  code_rdata,             // Code data
  input wire logic        cpu_stall,              // Core stall
  input wire logic        rst_pin_level,          // Reset pin
  input wire logic        programmer_select_n,    // Select, low
  input wire logic        programmer_read_enable, // Read allowed
  input wire logic        safe_mode_active        // Unlock window
);
  localparam int STALL_MAX = TOUT_CYCLES + LONG_RESET_CYCLES + 4;
  logic        cmd_wr;
  logic        key_wr;
  logic        bad_cmd_q;
  int unsigned stall_cnt_q;
  // Command and second key writes
  assign cmd_wr = sfr_wr && sfr_addr == 8'h86;
  assign key_wr = sfr_wr && sfr_addr == 8'h90 && sfr_wdata == 8'haa;
  // Last accepted command value was unknown
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      bad_cmd_q <= 1'b0;
    else if (cmd_wr && !cpu_stall)
      bad_cmd_q <= sfr_wdata != 8'ha6 && sfr_wdata != 8'h9a;
  // Length of the current stall
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      stall_cnt_q <= 0;
    else
      stall_cnt_q <= cpu_stall ? stall_cnt_q + 1 : 0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_read_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  a_status_fixed: assert property (sfr_rd && sfr_addr == 8'h86 |=>
    sfr_rdata[7] && sfr_rdata[5:2] == 4'h0) else $error("status fixed bits wrong");
  a_cmd_error: assert property (sfr_rd && sfr_addr == 8'h86 |=>
    sfr_rdata[1] == bad_cmd_q) else $error("command error bit wrong");
  a_select_gate: assert property (programmer_select_n || !rst_pin_level |->
    !programmer_read_enable) else $error("programmer read without select");
  a_stall_cause: assert property ($rose(cpu_stall) |-> $past(cmd_wr))
    else $error("stall without command");
  a_stall_hold: assert property ($rose(cpu_stall) |-> cpu_stall[*8])
    else $error("stall too short");
  a_stall_bound: assert property (stall_cnt_q <= STALL_MAX)
    else $error("stall exceeds timeout");
  a_code_hold: assert property (!code_rd |=> $stable(code_rdata))
    else $error("code data changed without read");
  a_safe_bound: assert property ($rose(safe_mode_active) |->
    ##[1:23] !safe_mode_active) else $error("unlock window too long");
  a_safe_cause: assert property ($rose(safe_mode_active) |-> $past(key_wr))
    else $error("unlock window without key");
  c_stall: cover property ($rose(cpu_stall));
  c_safe: cover property ($rose(safe_mode_active));
  c_err: cover property (sfr_rd && sfr_addr == 8'h86 ##1 sfr_rdata[1]);
endmodule // fre_checker
bind fre_ctrl fre_checker #(
  .TOUT_CYCLES(TOUT_CYCLES),
  .LONG_RESET_CYCLES(LONG_RESET_CYCLES)
) u_chk (.sys_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .code_rd, .code_rdata, .cpu_stall, .rst_pin_level, .programmer_select_n,
  .programmer_read_enable, .safe_mode_active);
`default_nettype wire

// ==== fre_core_model.sv ====
// Processor core model issuing register accesses and commands
`timescale 1ns/1ps
`default_nettype none
module fre_core_model (
  input  wire logic       sys_clk,   // Clock
  input  wire logic       cpu_stall, // Core held
  input  wire logic [7:0] sfr_rdata, // Read data
  output var  logic [7:0] sfr_addr,  // Address
  output var  logic [7:0] sfr_wdata, // Write data
  output var  logic       sfr_wr,    // Write strobe
  output var  logic       sfr_rd     // Read strobe
);
  // Quiet bus at time zero
  initial
  begin
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
  end
  // One write cycle; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~d;
  endtask
  // One read cycle; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
    sfr_addr <= ~a;
    #1 d = sfr_rdata;
  endtask
  // Key pair that opens the unlock window
  task automatic unlock();
    wr(8'h90, 8'h55);
    wr(8'h90, 8'haa);
  endtask
  // Command write, then wait while the core is held
  task automatic cmd(input logic [7:0] c, output logic st);
    wr(8'h86, c);
    #1 st = cpu_stall;
    repeat (700)
      if (cpu_stall)
      begin
        @(posedge sys_clk);
        #1;
      end
  endtask
endmodule // fre_core_model
`default_nettype wire

// ==== flash_rom_program_erase_control_test.sv ====
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_rom_program_erase_control_test;
  localparam logic [15:0] W0 = 16'h1234; // Arbitrary ID word
  localparam logic [15:0] W1 = 16'h5678; // Arbitrary ID word
  localparam logic [15:0] W2 = 16'h9abc; // Arbitrary ID word
  localparam logic [15:0] CSUM = W0 + W1 + W2;
  logic sys_clk, rstn, sfr_wr, sfr_rd, code_rd, cpu_stall, st;
  logic interrupt_block_flag, global_int_disabled, rst_pin_level, programmer_select_n;
  logic programming_state, programmer_read_enable, extended_reset_hold;
  logic external_reset_pin_enable, port0_reset_pullup_enable, crystal_drive_boost;
  logic safe_mode_active;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, code_rdata, d;
  logic [15:0] code_addr, boot_start_addr;
  int n_errors, comparisons;
  fre_ctrl #(.ERASE_CYCLES(512), .WRITE_CYCLES(16), .TOUT_CYCLES(300),
    .LONG_RESET_CYCLES(20), .ID_W0(W0), .ID_W1(W1), .ID_W2(W2)) dut (
    .sys_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .code_rd,
    .code_addr, .code_rdata, .cpu_stall, .interrupt_block_flag, .global_int_disabled,
    .rst_pin_level, .programmer_select_n, .programming_state, .programmer_read_enable,
    .extended_reset_hold, .boot_start_addr, .external_reset_pin_enable,
    .port0_reset_pullup_enable, .crystal_drive_boost, .safe_mode_active);
  fre_core_model core (.sys_clk, .cpu_stall, .sfr_rdata, .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd);
  // Clock at 4 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Counted comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic srd(input logic [7:0] a, input logic [7:0] exp);
    core.rd(a, d);
    chk(d, exp);
  endtask
  // Code-space read, data in the next cycle
  task automatic crd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    code_rd   <= 1'b1;
    code_addr <= a;
    @(posedge sys_clk);
    code_rd   <= 1'b0;
    code_addr <= ~a;
    #1 chk(code_rdata, exp);
  endtask
  task automatic t_reset();
    chk(cpu_stall, 16'h0000);
    chk(boot_start_addr, 16'hf400);
    chk({external_reset_pin_enable, port0_reset_pullup_enable, crystal_drive_boost,
      extended_reset_hold}, 16'h000e);
  endtask
  task automatic t_regs();
    logic [7:0] a [4] = '{8'h84, 8'h85, 8'h8e, 8'h8f};
    logic [7:0] v [4] = '{8'h02, 8'he0, 8'h3c, 8'h5a};
    foreach (a[i])
      core.wr(a[i], v[i]);
    foreach (a[i])
      srd(a[i], v[i]);
    srd(8'h86, 8'h80);
    srd(8'h87, 8'h00);
  endtask
  task automatic t_cmd_err();
    core.cmd(8'h55, st);
    srd(8'h86, 8'h82);
    core.cmd(8'h9a, st);
    chk(st, 16'h0000);
    srd(8'h86, 8'h80);
  endtask
  task automatic t_program();
    core.unlock();
    core.wr(8'h91, 8'h04);
    srd(8'h86, 8'hc0);
    core.cmd(8'h9a, st);
    chk(st, 16'h0001);
    srd(8'h86, 8'hc0);
    crd(16'he002, 8'h3c);
    crd(16'he003, 8'h5a);
    core.wr(8'h84, 8'h03);
    core.wr(8'h8e, 8'h0f);
    core.wr(8'h8f, 8'hff);
    core.cmd(8'h9a, st);
    crd(16'he002, 8'h0c);
  endtask
  task automatic t_erase();
    core.wr(8'h85, 8'he3);
    core.wr(8'h84, 8'hfe);
    core.cmd(8'ha6, st);
    chk(st, 16'h0001);
    srd(8'h86, 8'hc1);
    crd(16'he002, 8'hff);
    crd(16'he400, 8'h00);
    core.unlock();
    core.wr(8'h91, 8'h00);
    core.cmd(8'ha6, st);
    srd(8'h86, 8'h80);
  endtask
  task automatic t_id();
    logic [7:0] e [8] = '{W0[7:0], W0[15:8], W1[7:0], W1[15:8], W2[7:0], W2[15:8],
      CSUM[7:0], CSUM[15:8]};
    crd(16'h0020, 8'hff);
    @(posedge sys_clk);
    interrupt_block_flag <= 1'b1;
    global_int_disabled  <= 1'b1;
    foreach (e[i])
      crd(16'h0020 + 16'(i), e[i]);
  endtask
  task automatic t_pins();
    @(posedge sys_clk);
    rst_pin_level       <= 1'b1;
    programmer_select_n <= 1'b0;
    @(posedge sys_clk);
    #1 chk({programming_state, programmer_read_enable}, 16'h0003);
    @(posedge sys_clk);
    programmer_select_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk({programming_state, programmer_read_enable}, 16'h0002);
  endtask
  task automatic t_reboot();
    dut.u_array.mem_q[15'h7fff] = 16'h2aff;
    @(posedge sys_clk);
    rstn                <= 1'b0;
    programmer_select_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk({cpu_stall, extended_reset_hold}, 16'h0003);
    @(posedge sys_clk);
    #1 chk({cpu_stall, extended_reset_hold}, 16'h0000);
    chk(boot_start_addr, 16'h0000);
    chk({external_reset_pin_enable, port0_reset_pullup_enable, crystal_drive_boost},
      16'h0004);
    chk({programming_state, programmer_read_enable}, 16'h0002);
    crd(16'he400, 8'h00);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #80000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end
  // Flash preload, reset, scenarios
  initial
  begin
    n_errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    code_rd = 1'b0;
    code_addr = 16'h0000;
    interrupt_block_flag = 1'b0;
    global_int_disabled = 1'b0;
    rst_pin_level = 1'b0;
    programmer_select_n = 1'b1;
    for (int i = 0; i < 32768; i++)
      dut.u_array.mem_q[i] = 16'hffff;
    dut.u_array.mem_q[15'h7fff] = 16'hdeff;
    dut.u_array.mem_q[15'h7200] = 16'h0000;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_regs();
    t_cmd_err();
    t_program();
    t_erase();
    t_id();
    t_pins();
    t_reboot();
    close_out();
  end
endmodule // flash_rom_program_erase_control_test
`default_nettype wire
